// *** rtl/cpl_cfg.svh ***
// register offsets, field positions, reset values for the cpu priority level block
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH
`define CPL_ADDR_STATUS 4'h0
`define CPL_ADDR_CORE 4'h1
`define CPL_ADDR_FLAGS 4'h2
`define CPL_ADDR_INTCTL 4'h3
`define CPL_ADDR_MASK 4'h4
`define CPL_ADDR_REQ 4'h5
`define CPL_ADDR_GRANT 4'h6
`define CPL_PRI_LSB 5
`define CPL_PRI_MSB 7
`define CPL_HIGH_BIT 3
`define CPL_NEST_BIT 15
`define CPL_RTC_BIT 14
`define CPL_DMA5_BIT 13
`define CPL_CODEC_EV_BIT 12
`define CPL_CODEC_ER_BIT 11
`define CPL_FLAGS_USED 16'h7800
`define CPL_RST_WORD 16'h0000
`endif

// *** rtl/cpl_pkg.sv ***
// types for the cpu priority level block
package cpl_pkg;
  typedef logic [15:0] cpl_word_t;
  typedef logic [3:0] cpl_addr_t;
  typedef logic [3:0] cpl_level_t;
  typedef logic [2:0] cpl_field_t;
endpackage

// *** rtl/cpl_top.sv ***
// cpu priority level status and interrupt flag status register block
`timescale 1ns/1ps
`include "cpl_cfg.svh"

// How it works
// - three bit priority field in status 7:5
// - high bit joins field as level msb
// - high bit set blocks every user interrupt
// - nesting disable makes priority field read only
// - high bit shows level above seven; clear-only
// - rtc and dma5 flags set on request
// - codec event and error flags set
// - unused flag bits read zero, ignore writes
module cpl_top (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire cpl_pkg::cpl_addr_t i_addr,
  input wire cpl_pkg::cpl_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output cpl_pkg::cpl_word_t o_rdata,
  input wire logic i_rtc_req,
  input wire logic i_dma5_req,
  input wire logic i_codec_ev_req,
  input wire logic i_codec_er_req,
  input wire logic i_user_req,
  input wire cpl_pkg::cpl_level_t i_user_pri,
  output logic o_user_take,
  output cpl_pkg::cpl_level_t o_level,
  output logic o_irq
);
  import cpl_pkg::*;

  // overview of the block:
  // the effective level is the high bit placed over the three bit field
  // a user request is taken only when its priority beats that level
  // and the high bit is clear; the high bit alone blocks every user request
  // the field ignores software writes while nesting is disabled
  // the high bit has no set source here, so software can only clear it
  // event pins are asynchronous and pass two flops before the edge detect
  // a level that stays high raises its flag once, on its rising edge only
  // every flag is sticky until software writes a one to that flag
  // a hardware set in the same cycle as a clear wins over the clear,
  // so an event landing on a clear is never lost
  // the interrupt line is registered from the next flag value so it
  // moves on the same edge as the flag itself
  // the mask has the flag layout; unused positions never hold a one
  // reads answer one cycle after the read strobe and are zero otherwise
  // unmapped indices read zero; writes to them are dropped
  // all outputs come straight from flops and are zero during reset

  ////////////////////////////////////////////////////////////////////////////
  // state
  cpl_field_t pri_field; // cpu priority field
  logic high_bit; // priority high bit
  logic nesting_disable; // interrupt control one bit 15
  cpl_word_t flags; // interrupt flag status three
  cpl_word_t mask; // interrupt enable mask
  cpl_level_t req_pri; // priority of the synchronised user request, mirrored one cycle late
  logic req_pend; // pending software-visible request
  logic [2:0] rtc_s; // rtc pin synchroniser and edge stage
  logic [2:0] dma_s; // dma5 pin synchroniser and edge stage
  logic [2:0] cev_s; // codec event pin synchroniser and edge stage
  logic [2:0] cer_s; // codec error pin synchroniser and edge stage
  logic [1:0] ureq_s; // user request synchroniser
  cpl_level_t upri_s0, upri_s1; // user priority synchroniser
  cpl_word_t next_flags; // flags after set and clear
  cpl_level_t level; // effective level
  logic take; // user interrupt accepted

  // write decode
  // one strobe per writable register; the read path decodes the index itself
  // the request and level views are read only, writes there are dropped
  wire wr_status = i_wr && (i_addr == `CPL_ADDR_STATUS);
  wire wr_core = i_wr && (i_addr == `CPL_ADDR_CORE);
  wire wr_flags = i_wr && (i_addr == `CPL_ADDR_FLAGS);
  wire wr_intctl = i_wr && (i_addr == `CPL_ADDR_INTCTL);
  wire wr_mask = i_wr && (i_addr == `CPL_ADDR_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for event pins
  // stage 0 may go metastable and is read only by stage 1
  // stage 2 is an extra flop kept for the edge detector
  // the user priority word is held stable by its source while requested,
  // so its two flop copy settles together with the request bit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rtc_s <= 3'h0;
      dma_s <= 3'h0;
      cev_s <= 3'h0;
      cer_s <= 3'h0;
      ureq_s <= 2'h0;
      upri_s0 <= 4'h0;
      upri_s1 <= 4'h0;
    end else begin
      rtc_s <= {rtc_s[1], rtc_s[0], i_rtc_req};
      dma_s <= {dma_s[1], dma_s[0], i_dma5_req};
      cev_s <= {cev_s[1], cev_s[0], i_codec_ev_req};
      cer_s <= {cer_s[1], cer_s[0], i_codec_er_req};
      ureq_s <= {ureq_s[0], i_user_req};
      upri_s0 <= i_user_pri;
      upri_s1 <= upri_s0;
    end
  end

  // rising edges of synchronised requests (stages 1 and 2 only)
  // stages reset low like the idle pins, so no false edge follows reset
  // a pin held high sets its flag once; it must drop before the next event
  wire rtc_ev = rtc_s[1] & ~rtc_s[2];
  wire dma_ev = dma_s[1] & ~dma_s[2];
  wire cev_ev = cev_s[1] & ~cev_s[2];
  wire cer_ev = cer_s[1] & ~cer_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // effective level and acceptance
  // the compare is unsigned over four bits, so levels 8 to 15 sit above
  // every priority of 7 or less; the high bit test also covers the case
  // where a priority of 15 would otherwise beat level 14
  always_comb begin
    level = {high_bit, pri_field};
    // high bit blocks all, else strictly above level
    take = ureq_s[1] && !high_bit && (upri_s1 > level);
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority field, write ignored under nesting disable
  // only bits 7:5 of the status word are kept here
  // a write in the cycle that sets nesting disable still lands
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pri_field <= 3'h0;
    end else if (wr_status && !nesting_disable) begin
      pri_field <= i_wdata[`CPL_PRI_MSB:`CPL_PRI_LSB];
    end
  end

  // high bit: software may only clear it
  // no exception entry is modelled, so nothing in hardware sets it;
  // writing a one to bit 3 is ignored, writing a zero clears it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_bit <= 1'b0;
    end else if (wr_core && !i_wdata[`CPL_HIGH_BIT]) begin
      high_bit <= 1'b0;
    end
  end

  // nesting disable control
  // only bit 15 of interrupt control one is kept
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nesting_disable <= 1'b0;
    end else if (wr_intctl) begin
      nesting_disable <= i_wdata[`CPL_NEST_BIT];
    end
  end

  // mask register, same layout as flags
  // unused positions are dropped on write so they read zero too
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask <= `CPL_RST_WORD;
    end else if (wr_mask) begin
      mask <= i_wdata & `CPL_FLAGS_USED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag status: write one clears, hardware set wins
  // the clear is applied first and the sets after it, so a set and a
  // clear of the same flag in one cycle leave the flag high
  always_comb begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags = flags & ~(i_wdata & `CPL_FLAGS_USED);
    end
    if (rtc_ev) begin
      next_flags[`CPL_RTC_BIT] = 1'b1;
    end
    if (dma_ev) begin
      next_flags[`CPL_DMA5_BIT] = 1'b1;
    end
    if (cev_ev) begin
      next_flags[`CPL_CODEC_EV_BIT] = 1'b1;
    end
    if (cer_ev) begin
      next_flags[`CPL_CODEC_ER_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags <= `CPL_RST_WORD;
    end else begin
      flags <= next_flags;
    end
  end

  // software-visible request view
  // mirrors the synchronised request and its priority one cycle late,
  // so software can see what the acceptance logic is comparing
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_pend <= 1'b0;
      req_pri <= 4'h0;
    end else begin
      req_pend <= ureq_s[1];
      req_pri <= upri_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and read port
  // every output is a flop; the irq flop follows next_flags so it
  // rises and falls on the same edge as the flag it reports
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_user_take <= 1'b0;
      o_level <= 4'h0;
      o_irq <= 1'b0;
    end else begin
      o_user_take <= take;
      o_level <= level;
      o_irq <= |(next_flags & mask);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= `CPL_RST_WORD;
    end else if (i_rd) begin
      unique case (i_addr)
        `CPL_ADDR_STATUS: o_rdata <= {8'h00, pri_field, 5'h00};
        `CPL_ADDR_CORE: o_rdata <= {12'h000, high_bit, 3'h0};
        `CPL_ADDR_FLAGS: o_rdata <= flags & `CPL_FLAGS_USED;
        `CPL_ADDR_INTCTL: o_rdata <= {nesting_disable, 15'h0000};
        `CPL_ADDR_MASK: o_rdata <= mask;
        `CPL_ADDR_REQ: o_rdata <= {11'h000, req_pend, req_pri};
        `CPL_ADDR_GRANT: o_rdata <= {12'h000, level};
        default: o_rdata <= `CPL_RST_WORD;
      endcase
    end else begin
      o_rdata <= `CPL_RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // each property watches state the block drives; reset quiets them all

  // field writes, the nesting lock and the level join
  field_locked_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    nesting_disable |=> $stable(pri_field))
    else $error("priority field changed while nesting disabled");
  field_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_status && !nesting_disable) |=> pri_field == $past(i_wdata[7:5]))
    else $error("priority field write lost");
  level_join_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ##1 o_level == {$past(high_bit), $past(pri_field)})
    else $error("level not high bit over field");
  high_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ##1 (o_level > 4'h7) == $past(high_bit))
    else $error("level above seven disagrees with high bit");

  // acceptance gating
  high_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    high_bit |=> !o_user_take)
    else $error("user interrupt taken with high bit set");
  high_noset_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !high_bit |=> !high_bit)
    else $error("high bit became set");
  take_req_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_user_take |-> $past(ureq_s[1]))
    else $error("take without a pending request");

  // flag set, clear, unused bits, irq line and strict take
  dma_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    dma_ev |=> flags[13])
    else $error("dma flag not set");
  rtc_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_flags && i_wdata[14] && !rtc_ev) |=> !flags[14])
    else $error("rtc flag not cleared by a one");
  codec_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_flags && i_wdata[12] && !cev_ev) |=> !flags[12])
    else $error("codec event flag not cleared by a one");
  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ##1 o_irq == |(flags & $past(mask)))
    else $error("irq line disagrees with masked flags");
  unused_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (flags & ~16'h7800) == 16'h0000)
    else $error("unused flag bit set");
  rtc_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rtc_ev |=> flags[14] && flags[13] >= $past(dma_ev))
    else $error("rtc or dma flag not set");
  codec_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (cev_ev || cer_ev) |=> (flags[12] || !$past(cev_ev)) && (flags[11] || !$past(cer_ev)))
    else $error("codec flag not set");
  unused_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == 4'h2) |=> (o_rdata & ~16'h7800) == 16'h0000)
    else $error("unused flag bits not zero");
  strict_take_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_user_take |-> $past(upri_s1) > $past(level))
    else $error("take without strictly higher priority");
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the cpu priority level block
`timescale 1ns/1ps
`include "cpl_cfg.svh"
module tb_top;
  import cpl_pkg::*;
  logic i_clk = 1'b0; // system clock
  logic i_rst_b = 1'b0; // async reset, active low
  cpl_addr_t i_addr = 4'h0;
  cpl_word_t i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] ev = 4'h0; // event pins: rtc, dma5, codec event, codec error
  logic i_user_req = 1'b0;
  cpl_level_t i_user_pri = 4'h0;
  cpl_word_t o_rdata;
  cpl_level_t o_level;
  logic o_user_take;
  logic o_irq;
  int err_total = 0;
  int n_tests = 0;
  cpl_word_t rv; // last read value
  int i;
  //////////////////////////////////////////////////////////////////////////////
  // clock, 40 ns period
  always #20 i_clk = ~i_clk;
  cpl_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rtc_req(ev[3]), .i_dma5_req(ev[2]), .i_codec_ev_req(ev[1]),
    .i_codec_er_req(ev[0]), .i_user_req(i_user_req), .i_user_pri(i_user_pri),
    .o_user_take(o_user_take), .o_level(o_level), .o_irq(o_irq));
  //////////////////////////////////////////////////////////////////////////////
  // one-cycle write strobe
  task automatic wr(input cpl_addr_t a, input cpl_word_t d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input cpl_addr_t a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  // word compare, four-state exact
  task automatic chk(input string name, input cpl_word_t exp, input cpl_word_t got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // event pin held high long enough to pass the synchroniser
  task automatic pulse(input int k);
    @(posedge i_clk);
    ev[k] <= 1'b1;
    repeat (5) @(posedge i_clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the roughly 170 cycles the tests need
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rd(`CPL_ADDR_STATUS);
    chk("status reset", `CPL_RST_WORD, rv);
    rd(`CPL_ADDR_CORE);
    chk("core reset", `CPL_RST_WORD, rv);
    rd(`CPL_ADDR_FLAGS);
    chk("flags reset", `CPL_RST_WORD, rv);
    $display("test reset done");
    // field write, level and acceptance
    wr(`CPL_ADDR_STATUS, 16'h00a0);
    rd(`CPL_ADDR_STATUS);
    chk("status field", 16'h00a0, rv & 16'h00e0);
    chk("level", 16'h0005, {12'h000, o_level});
    i_user_pri <= 4'h5;
    i_user_req <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk("take equal", 16'h0000, {15'h0000, o_user_take});
    i_user_pri <= 4'h6;
    repeat (4) @(posedge i_clk);
    chk("take above", 16'h0001, {15'h0000, o_user_take});
    rd(`CPL_ADDR_REQ);
    chk("request view", 16'h0016, rv);
    rd(`CPL_ADDR_GRANT);
    chk("level view", 16'h0005, rv);
    // software cannot raise the high bit
    wr(`CPL_ADDR_CORE, 16'h0008);
    rd(`CPL_ADDR_CORE);
    chk("high bit", 16'h0000, rv & 16'h0008);
    chk("level kept", 16'h0005, {12'h000, o_level});
    $display("test level done");
    // nesting disable freezes the field
    wr(`CPL_ADDR_INTCTL, 16'h8000);
    wr(`CPL_ADDR_STATUS, 16'h0020);
    rd(`CPL_ADDR_STATUS);
    chk("field frozen", 16'h00a0, rv & 16'h00e0);
    wr(`CPL_ADDR_INTCTL, 16'h0000);
    wr(`CPL_ADDR_STATUS, 16'h00e0);
    rd(`CPL_ADDR_STATUS);
    chk("field free", 16'h00e0, rv & 16'h00e0);
    i_user_pri <= 4'h7;
    repeat (4) @(posedge i_clk);
    chk("level seven blocks", 16'h0000, {15'h0000, o_user_take});
    i_user_req <= 1'b0;
    $display("test nesting done");
    // each flag set by its event and cleared by a one
    for (i = 0; i < 4; i++) begin
      pulse(3 - i);
      rd(`CPL_ADDR_FLAGS);
      chk("flag set", 16'h4000 >> i, rv);
      chk("irq masked", 16'h0000, {15'h0000, o_irq});
      wr(`CPL_ADDR_FLAGS, 16'h4000 >> i);
      rd(`CPL_ADDR_FLAGS);
      chk("flag clear", 16'h0000, rv);
    end
    // mask gates the interrupt line
    wr(`CPL_ADDR_MASK, 16'h2000);
    pulse(2);
    chk("irq on", 16'h0001, {15'h0000, o_irq});
    wr(`CPL_ADDR_MASK, 16'h0000);
    repeat (2) @(posedge i_clk);
    chk("irq masked off", 16'h0000, {15'h0000, o_irq});
    wr(`CPL_ADDR_MASK, 16'h2000);
    wr(`CPL_ADDR_FLAGS, 16'h2000);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", 16'h0000, {15'h0000, o_irq});
    $display("test flags done");
    // unused bits read zero, writes there ignored
    pulse(3);
    pulse(2);
    pulse(1);
    pulse(0);
    wr(`CPL_ADDR_FLAGS, 16'h87ff);
    rd(`CPL_ADDR_FLAGS);
    chk("unused bits", `CPL_FLAGS_USED, rv);
    wr(`CPL_ADDR_FLAGS, 16'hffff);
    rd(`CPL_ADDR_FLAGS);
    chk("all cleared", 16'h0000, rv);
    rd(4'hf);
    chk("unmapped", 16'h0000, rv);
    $display("test unused done");
    print_verdict();
  end
endmodule
